/* bench/dos_bus_model.sv */
// Behavioural DC bus of the power stage
`default_nettype none
module dos_bus_model #(
  parameter int VW  = 10,
  parameter int NOM = 300
) (
  // Stimulus
  input wire logic          ref_clk,
  input wire logic          regen,
  input wire logic [VW-1:0] surgeVolt,
  // Sense line
  output var logic [VW-1:0] busVoltage
);
  timeunit 1ns;
  timeprecision 1ps;
  // No braking chopper, so regenerated energy stays on the bus
  always_ff @(posedge ref_clk) busVoltage <= regen ? surgeVolt : VW'(NOM);
endmodule // dos_bus_model
`default_nettype wire

/* bench/dos_checker.sv */
// Port checker for the suppressor
`default_nettype none
module dos_checker #(
  parameter int FW = 24,
  parameter int VW = 10
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // Watched ports
  input wire logic              clkEn,
  input wire dos_pkg::dos_cfg_s cfg,
  input wire logic [FW-1:0]     rampFreq,
  input wire logic [FW-1:0]     outFreq,
  input wire logic              suppressing,
  input wire logic [VW-1:0]     levelInUse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic inLo, inHi, off;
  assign inLo = cfg.level >= dos_pkg::LEVEL_LO_MIN && cfg.level <= dos_pkg::LEVEL_LO_MAX;
  assign inHi = cfg.level >= dos_pkg::LEVEL_HI_MIN && cfg.level <= dos_pkg::LEVEL_HI_MAX;
  assign off = cfg.mode == dos_pkg::DOS_MODE_OFF;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_lo_pass: assert property (clkEn && !cfg.voltClass && inLo |=> levelInUse == $past(cfg.level))
    else $error("low class level not kept");
  a_lo_default: assert property (clkEn && !cfg.voltClass && !inLo |=> levelInUse == dos_pkg::LEVEL_LO_DEF)
    else $error("low class default missing");
  a_hi_pass: assert property (clkEn && cfg.voltClass && inHi |=> levelInUse == $past(cfg.level))
    else $error("high class level not kept");
  a_hi_default: assert property (clkEn && cfg.voltClass && !inHi |=> levelInUse == dos_pkg::LEVEL_HI_DEF)
    else $error("high class default missing");
  a_off_follow: assert property (clkEn && off |=> outFreq == $past(rampFreq))
    else $error("ramp altered while off");
  a_rsvd_follow: assert property (clkEn && cfg.mode == dos_pkg::DOS_MODE_RSVD |=> outFreq == $past(rampFreq))
    else $error("reserved mode altered ramp");
  a_off_quiet: assert property ((clkEn && off) [*2] |-> !suppressing)
    else $error("suppressing while off");
  a_accel_rise: assert property (clkEn && $past(clkEn) && suppressing && cfg.mode == dos_pkg::DOS_MODE_ACCEL
    && $past(cfg.mode) == dos_pkg::DOS_MODE_ACCEL |=> outFreq >= $past(outFreq))
    else $error("output fell while accelerating");
  a_freeze_hold: assert property (!clkEn |=> $stable(outFreq) && $stable(suppressing) && $stable(levelInUse))
    else $error("outputs moved while frozen");
  c_accel: cover property ($rose(suppressing));
  c_const: cover property (cfg.mode == dos_pkg::DOS_MODE_CONST && suppressing);
  c_lo_def: cover property (!cfg.voltClass && !inLo);
  c_hi_pass: cover property (cfg.voltClass && inHi);
endmodule // dos_checker
bind dos_suppressor dos_checker #(.FW(FW), .VW(VW)) chk (.ref_clk, .rst, .clkEn, .cfg, .rampFreq, .outFreq,
  .suppressing, .levelInUse);
`default_nettype wire

/* bench/tb.sv */
// Testbench of the suppressor
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, clkEn, decelerating, regen, suppressing;
  dos_pkg::dos_cfg_s cfg;
  logic [23:0] rampFreq, decelStep, outFreq, held;
  logic [9:0] busVoltage, surgeVolt, levelInUse;
  int mismatches, cmp_count;
  int edges[8] = '{329, 330, 390, 391, 659, 660, 780, 781};
  // Short update period keeps the run brief
  dos_suppressor #(.TICK(100)) DUT (.ref_clk, .rst, .clkEn, .cfg, .decelerating, .rampFreq, .decelStep, .busVoltage,
    .outFreq, .suppressing, .levelInUse);
  dos_bus_model bus (.ref_clk, .regen, .surgeVolt, .busVoltage);
  function automatic int expLevel(int cls, int lv);
    if (cls == 0) return (lv >= 330 && lv <= 390) ? lv : 380;
    return (lv >= 660 && lv <= 780) ? lv : 760;
  endfunction
  function automatic int clampAccel(int a);
    return a < 10 ? 10 : (a > 3000 ? 3000 : a);
  endfunction
  task automatic check(string what, int e, logic [23:0] v);
    cmp_count++;
    if (v !== 24'(e)) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", what, e, v);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  // About 510 cycles of tests, with margin
  initial begin
    #30000;
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h296A));
    {rst, clkEn, decelerating, regen} = 4'hC;
    {surgeVolt, rampFreq, decelStep} = {10'h190, 24'h1000, 24'h10};
    cfg = '{2'h0, 1'h0, 10'h17C, 16'h64, 8'h32, 16'h3C};
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) rst = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      cfg.mode = i[1] ? dos_pkg::DOS_MODE_RSVD : dos_pkg::DOS_MODE_OFF;
      cfg.voltClass = i < 8 ? i >= 4 : i[0];
      cfg.level = i < 8 ? 10'(edges[i]) : 10'($urandom_range(800, 300));
      rampFreq = 24'($urandom());
      @(negedge ref_clk);
      check("levelInUse", expLevel(cfg.voltClass, cfg.level), 24'(levelInUse));
      check("outFreq", rampFreq, outFreq);
    end
    // Frozen enable must hold the outputs
    held = outFreq;
    clkEn = 1'b0;
    rampFreq = ~rampFreq;
    repeat (3) @(negedge ref_clk);
    check("outFreq", held, outFreq);
    clkEn = 1'b1;
    // Constant-voltage mode: a bus above the level stops the drop
    cfg = '{dos_pkg::DOS_MODE_CONST, 1'h0, 10'h17C, 16'h64, 8'h32, 16'h3C};
    {rampFreq, decelerating} = {24'h8000, 1'b1};
    repeat (10) @(negedge ref_clk);
    check("suppressing", 0, 24'(suppressing));
    regen = 1'b1;
    repeat (10) @(negedge ref_clk);
    check("suppressing", 1, 24'(suppressing));
    rampFreq = 24'h7000;
    repeat (250) @(negedge ref_clk);
    check("outFreq", 32768, outFreq);
    regen = 1'b0;
    repeat (10) @(negedge ref_clk);
    check("outFreq", 28672, outFreq);
    // Surge in accel mode with a rate below the floor
    cfg = '{dos_pkg::DOS_MODE_ACCEL, 1'h0, 10'h17C, 16'h5, 8'h32, 16'h3C};
    {rampFreq, decelStep} = {24'h8000, 24'h4};
    repeat (10) @(negedge ref_clk);
    check("outFreq", 32768, outFreq);
    regen = 1'b1;
    repeat (10) @(negedge ref_clk);
    check("suppressing", 1, 24'(suppressing));
    for (int n = 0; n < 300 && outFreq == 24'h8000; n++) @(negedge ref_clk);
    check("outFreq", 32768 + clampAccel(5), outFreq);
    regen = 1'b0;
    repeat (10) @(negedge ref_clk);
    check("suppressing", 0, 24'(suppressing));
    for (int n = 0; n < 300 && outFreq == 24'h800A; n++) @(negedge ref_clk);
    check("outFreq", 32768 + clampAccel(5) - 4, outFreq);
    finish_test();
  end
endmodule // tb
`default_nettype wire

/* src/dos_pkg.sv */
// Package for the deceleration overvoltage suppressor: modes, ranges, defaults
`default_nettype none
package dos_pkg;

  // ==========================================================================
  // Mode selection codes
  typedef enum logic [1:0] {
    DOS_MODE_OFF   = 2'b00,
    DOS_MODE_CONST = 2'b01,
    DOS_MODE_ACCEL = 2'b10,
    DOS_MODE_RSVD  = 2'b11
  } dos_mode_e;

  // ==========================================================================
  // Voltage level, volts; class 0 is the lower class, class 1 the higher
  localparam logic [9:0] LEVEL_LO_MIN = 10'd330;
  localparam logic [9:0] LEVEL_LO_MAX = 10'd390;
  localparam logic [9:0] LEVEL_LO_DEF = 10'd380;
  localparam logic [9:0] LEVEL_HI_MIN = 10'd660;
  localparam logic [9:0] LEVEL_HI_MAX = 10'd780;
  localparam logic [9:0] LEVEL_HI_DEF = 10'd760;

  // Accel rate in hundredths: 0.10 .. 30.00, default 1.00
  localparam logic [15:0] ACCEL_MIN = 16'd10;
  localparam logic [15:0] ACCEL_MAX = 16'd3000;
  localparam logic [15:0] ACCEL_DEF = 16'd100;

  // Proportional gain in hundredths: 0.00 .. 2.55, default 0.50
  localparam logic [7:0] KP_DEF = 8'd50;

  // Integral time in milliseconds: 0 .. 65530, default 60 (0.060 s)
  localparam logic [15:0] TI_MAX = 16'd65530;
  localparam logic [15:0] TI_DEF = 16'd60;

  // ==========================================================================
  // Time base of the ramp update: 1 ms at 100 MHz
  localparam int CLK_HZ       = 100000000;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = CLK_HZ / 1000000 * TICK_US;

  // Configuration carrier
  typedef struct packed {
    logic [1:0]  mode;
    logic        voltClass;
    logic [9:0]  level;
    logic [15:0] accelRate;
    logic [7:0]  propGain;
    logic [15:0] integralTime;
  } dos_cfg_s;

endpackage : dos_pkg
`default_nettype wire

/* src/dos_suppressor.sv */
// Deceleration ramp shaper that holds down the DC bus during braking
`default_nettype none
// How it works
// - Mode 01 slows deceleration to hold level
// - Mode 01 runs PI loop on bus
// - Mode 02 accelerates above level at rate
// - Mode 02 resumes deceleration below level
// - Level outside class range falls back to class default
// - Accel rate clamped 0.10 to 30.00
// - Proportional gain used in mode 01 only
// - Integral time used in mode 01 only
module dos_suppressor #(
  parameter int FW   = 24,
  parameter int VW   = 10,
  // Ramp update period in clock cycles
  parameter int TICK = dos_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          clkEn,
  // Configuration
  input  wire dos_pkg::dos_cfg_s cfg,
  // Ramp interface
  input  wire logic          decelerating,
  input  wire logic [FW-1:0] rampFreq,
  input  wire logic [FW-1:0] decelStep,
  input  wire logic [VW-1:0] busVoltage,
  // Outputs
  output var  logic [FW-1:0] outFreq,
  output var  logic          suppressing,
  output var  logic [VW-1:0] levelInUse
);

  // ==========================================================================
  // Synchronise the sampled bus voltage; it comes from a converter off-clock
  // Only the second stage feeds logic; the first may still be settling
  logic [VW-1:0] busMeta;
  logic [VW-1:0] busSync;
  logic [VW-1:0] busPrev;
  logic [VW-1:0] busStable;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busMeta <= '0;
      busSync <= '0;
    end else if (clkEn) begin
      busMeta <= busVoltage;
      busSync <= busMeta;
    end
  end

  // A word caught mid-change can be garbage; take it only when two samples agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busPrev   <= '0;
      busStable <= '0;
    end else if (clkEn) begin
      busPrev <= busSync;
      if (busSync == busPrev)
        busStable <= busSync;
    end
  end

  // ==========================================================================
  // Configuration clamps
  // Bad level falls back to the class default; rate and time saturate
  // Regenerative braking must already be off; nothing here checks it
  logic [9:0]  next_level;
  logic [15:0] accelEff;
  logic [15:0] tiEff;
  always_comb begin
    if (cfg.voltClass) begin
      if (cfg.level < dos_pkg::LEVEL_HI_MIN || cfg.level > dos_pkg::LEVEL_HI_MAX)
        next_level = dos_pkg::LEVEL_HI_DEF;
      else
        next_level = cfg.level;
    end else begin
      if (cfg.level < dos_pkg::LEVEL_LO_MIN || cfg.level > dos_pkg::LEVEL_LO_MAX)
        next_level = dos_pkg::LEVEL_LO_DEF;
      else
        next_level = cfg.level;
    end
    if (cfg.accelRate < dos_pkg::ACCEL_MIN)
      accelEff = dos_pkg::ACCEL_MIN;
    else if (cfg.accelRate > dos_pkg::ACCEL_MAX)
      accelEff = dos_pkg::ACCEL_MAX;
    else
      accelEff = cfg.accelRate;
    tiEff = (cfg.integralTime > dos_pkg::TI_MAX) ? dos_pkg::TI_MAX : cfg.integralTime;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      levelInUse <= '0;
    end else if (clkEn) begin
      levelInUse <= VW'(next_level);
    end
  end

  // ==========================================================================
  // Update tick
  // Counter holds with the enable, so a frozen block stretches the period
  localparam int TW = $clog2(TICK + 1);
  logic [TW-1:0] tickCnt;
  logic          tick;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickCnt <= '0;
      tick    <= 1'b0;
    end else if (clkEn) begin
      tick <= (tickCnt == TW'(TICK - 1));
      if (tickCnt == TW'(TICK - 1))
        tickCnt <= '0;
      else
        tickCnt <= tickCnt + TW'(1);
    end
  end

  // ==========================================================================
  // PI correction: error in volts, result is a frequency add-back
  logic signed [VW+1:0] err;
  logic signed [31:0]   integ;
  logic signed [31:0]   propTerm;
  logic signed [31:0]   corr;
  logic signed [31:0]   next_integ;
  always_comb begin
    err        = $signed({2'b00, busStable}) - $signed({2'b00, levelInUse});
    propTerm   = 32'(err) * $signed({24'h000000, cfg.propGain});
    // Zero integral time disables the integrator rather than dividing by zero
    if (tiEff == 16'h0000)
      next_integ = '0;
    else
      next_integ = integ + (32'(err) * 32'sd1000) / $signed({16'h0000, tiEff});
    // Clipped at zero: the loop may only hold the ramp back, never push it
    if (next_integ < 0)
      next_integ = '0;
    corr = propTerm + integ;
    if (corr < 0)
      corr = '0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      integ <= '0;
    end else if (clkEn) begin
      // Cleared outside mode 01 so a later entry starts clean
      if (cfg.mode != dos_pkg::DOS_MODE_CONST || !decelerating)
        integ <= '0;
      else if (tick)
        integ <= next_integ;
    end
  end

  // ==========================================================================
  // Output frequency shaping
  logic          overLevel;
  logic [FW-1:0] heldFreq;
  logic [FW-1:0] accelStepF;
  logic [FW:0]   sumFreq;
  assign overLevel  = busStable > levelInUse;
  assign accelStepF = FW'(accelEff);
  // Extra bit lets an accelerating ramp saturate instead of wrapping
  assign sumFreq    = {1'b0, heldFreq} + {1'b0, accelStepF};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      heldFreq    <= '0;
      suppressing <= 1'b0;
    end else if (clkEn) begin
      unique case (dos_pkg::dos_mode_e'(cfg.mode))
        dos_pkg::DOS_MODE_CONST: begin
          // Add back part of the commanded drop while the bus is high
          if (decelerating && corr > 0) begin
            suppressing <= 1'b1;
            if (tick && heldFreq > rampFreq)
              heldFreq <= heldFreq - ((32'(decelStep) > corr) ? FW'(32'(decelStep) - corr) : '0);
            else if (heldFreq < rampFreq)
              heldFreq <= rampFreq;
          end else begin
            suppressing <= 1'b0;
            heldFreq    <= rampFreq;
          end
        end
        dos_pkg::DOS_MODE_ACCEL: begin
          if (decelerating && overLevel) begin
            suppressing <= 1'b1;
            if (tick)
              heldFreq <= sumFreq[FW] ? '1 : sumFreq[FW-1:0];
          end else if (decelerating && heldFreq > rampFreq) begin
            // Fall back toward the ramp at the commanded rate
            suppressing <= 1'b0;
            if (tick)
              heldFreq <= (heldFreq - rampFreq > decelStep) ? heldFreq - decelStep : rampFreq;
          end else begin
            suppressing <= 1'b0;
            heldFreq    <= rampFreq;
          end
        end
        default: begin
          suppressing <= 1'b0;
          heldFreq    <= rampFreq;
        end
      endcase
    end
  end

  // ==========================================================================
  // Output register; mode 11 is reserved and passes the ramp like mode 00
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outFreq <= '0;
    end else if (clkEn) begin
      if (cfg.mode == dos_pkg::DOS_MODE_OFF || cfg.mode == dos_pkg::DOS_MODE_RSVD)
        outFreq <= rampFreq;
      else
        outFreq <= heldFreq;
    end
  end

endmodule // dos_suppressor
`default_nettype wire
